/* File: dv/ctrl_model.sv */
// Purpose: remote controller
// Assumes: read answer one cycle on
// Notes: drives at falling edge
`timescale 1ns/100ps
module ctrl_model(
  input wire logic clk_i,
  input wire logic rvalid_i,
  input wire logic [7:0] rdata_i,
  output logic rd_o = 1'b0,
  output logic [1:0] sel_o = 2'h0
);
  task automatic read(input logic [1:0] s, output logic ok,
    output logic [7:0] d);
    @(negedge clk_i);
    rd_o = 1'b1;
    sel_o = s;
    @(negedge clk_i);
    rd_o = 1'b0;
    ok = rvalid_i;
    d = rdata_i;
  endtask
endmodule // ctrl_model

/* File: dv/sbsr_sva.sv */
// Purpose: port checker
// Assumes: one clock
// Notes: bound below
`timescale 1ns/100ps
module sbsr_sva(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic err_queue_empty_i,
  input wire logic out_queue_empty_i,
  input wire logic sre_wr_i,
  input wire logic [15:0] wdata_i,
  input wire logic rd_i,
  input wire logic [1:0] rd_sel_i,
  input wire logic [7:0] rdata_o,
  input wire logic rvalid_o,
  input wire logic [7:0] summary_status_byte_o,
  input wire logic master_summary_o,
  input wire logic service_request_flag_o
);
  logic [7:0] sre_q;
  wire [7:0] s = summary_status_byte_o;
  wire m = master_summary_o;
  wire [7:0] poll_view = {s[7], m, s[5:0]};
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) sre_q <= 8'h00;
    else if (sre_wr_i) sre_q <= wdata_i[7:0];
  end
  chk_errq_bit: assert property (
    !$past(rst_i) |-> s[2] == !$past(err_queue_empty_i)) else $error("b2");
  chk_msgw_bit: assert property (
    !$past(rst_i) |-> s[4] == !$past(out_queue_empty_i)) else $error("b4");
  chk_rsv_zero: assert property (
    s[1:0] == 2'h0 && !s[6]) else $error("rsv");
  chk_mss_value: assert property (
    $stable(sre_q) && $stable(s) |-> m == |(s & sre_q & 8'hbc))
    else $error("mss");
  chk_rqs_flag: assert property (
    service_request_flag_o == m) else $error("rqs");
  chk_rvalid_pulse: assert property (
    !$past(rst_i) |-> rvalid_o == $past(rd_i)) else $error("rv");
  chk_read_data: assert property (
    rd_i && !rd_sel_i[1] |=> rdata_o == $past(poll_view)) else $error("rd");
  chk_sre_read: assert property (
    rd_i && rd_sel_i == 2'h2 |=> rdata_o == $past(sre_q)) else $error("sre");
  chk_rdata_hold: assert property (
    !rd_i |=> $stable(rdata_o)) else $error("hold");
endmodule // sbsr_sva
bind status_byte_service_request sbsr_sva u_sbsr_sva(.*);

/* File: dv/testbench.sv */
// Purpose: bench
// Assumes: sync reset
// Notes: no random
`timescale 1ns/100ps
module testbench;
  import status_byte_pkg::*;
  logic clk = 1'b0, rst = 1'b1, eqe = 1'b1, oqe = 1'b1;
  logic [15:0] qev = '0, oev = '0, wd = '0;
  logic [7:0] sev = '0, rdata, sb, got;
  logic [3:0] we = '0;
  logic rd, rv, ms, rf, ok;
  logic [1:0] sel;
  int n_mismatch = 0, n_tests = 0;
  always #2 clk = ~clk;
  status_byte_service_request u_status_byte_service_request(
    .sys_clk_i(clk), .rst_i(rst), .err_queue_empty_i(eqe),
    .out_queue_empty_i(oqe), .ques_event_i(qev), .oper_event_i(oev),
    .std_event_i(sev), .sre_wr_i(we[0]), .std_en_wr_i(we[1]),
    .ques_en_wr_i(we[2]), .oper_en_wr_i(we[3]), .wdata_i(wd), .rd_i(rd),
    .rd_sel_i(sel), .rdata_o(rdata), .rvalid_o(rv),
    .summary_status_byte_o(sb), .master_summary_o(ms),
    .service_request_flag_o(rf));
  ctrl_model u_ctrl_model(.clk_i(clk), .rvalid_i(rv), .rdata_i(rdata),
    .rd_o(rd), .sel_o(sel));
  task automatic chk(input logic [7:0] g, e);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %0t %h %h", $time, g, e);
    end
  endtask
  task automatic wr(input int i, input logic [15:0] d);
    @(negedge clk);
    we[i] = 1'b1;
    wd = d;
    @(negedge clk);
    we = '0;
  endtask
  task automatic rdc(input logic [1:0] s, input logic [7:0] e);
    repeat (3) @(negedge clk);
    u_ctrl_model.read(s, ok, got);
    chk({7'h0, ok}, 8'h01);
    chk(got, e);
  endtask
  task automatic t_sources();
    rdc(RD_STDEN, 8'h00);
    eqe = 1'b0;
    oqe = 1'b0;
    qev = 16'h8001;
    oev = 16'h0100;
    sev = 8'h10;
    wr(0, 16'h00ff);
    rdc(RD_QUERY, 8'h54);
    wr(1, 16'h0010);
    wr(2, 16'h8000);
    wr(3, 16'h0100);
    rdc(RD_QUERY, 8'hfc);
  endtask
  task automatic t_mask();
    wr(0, 16'h0043);
    rdc(RD_POLL, 8'hbc);
    rdc(RD_SRE, 8'h43);
    wr(0, 16'h0000);
    rdc(RD_QUERY, 8'hbc);
    chk({6'h0, ms, rf}, 8'h00);
    for (int i = 2; i < 8; i++) if (i != 6) begin
      wr(0, 16'h1 << i);
      rdc(RD_QUERY, 8'hfc);
    end
  endtask
  task automatic t_noside();
    rdc(RD_QUERY, 8'hfc);
    chk({7'h0, rf}, 8'h01);
    chk({7'h0, ms}, 8'h01);
    chk(sb, 8'hbc);
    eqe = 1'b1;
    rdc(RD_POLL, 8'hf8);
    chk(sb, 8'hb8);
    qev = 16'h0000;
    rdc(RD_POLL, 8'hf0);
  endtask
  task automatic tally_and_finish();
    $display("mismatches %0d tests %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(negedge clk);
    rst = 1'b0;
    t_sources();
    t_mask();
    t_noside();
    tally_and_finish();
  end
endmodule // testbench

/* File: inc/status_byte_pkg.sv */
// Purpose: constants for the summary status byte and service request logic
// Assumes: 8-bit status byte, 8-bit SRE and standard enable masks, 16-bit questionable and operation enable masks
// Notes: widths, bit positions, reset values, summary source mask and read select codes
package status_byte_pkg;
  localparam int unsigned STB_W = 8;
  localparam int unsigned QUES_W = 16;
  localparam int unsigned OPER_W = 16;
  localparam int unsigned STD_W = 8;
  localparam int unsigned ERR_CNT_W = 8;
  localparam int unsigned OUTQ_CNT_W = 8;
  // status byte bit positions
  localparam int unsigned BIT_RSV0 = 0;
  localparam int unsigned BIT_RSV1 = 1;
  localparam int unsigned BIT_ERRQ = 2;
  localparam int unsigned BIT_QUES = 3;
  localparam int unsigned BIT_MSGW = 4;
  localparam int unsigned BIT_STDE = 5;
  localparam int unsigned BIT_MSUM = 6;
  localparam int unsigned BIT_OPER = 7;
  // reset values
  localparam logic [7:0] SRE_RST = 8'h00;
  localparam logic [7:0] STD_EN_RST = 8'h00;
  localparam logic [15:0] QUES_EN_RST = 16'h0000;
  localparam logic [15:0] OPER_EN_RST = 16'h0000;
  localparam logic [7:0] STB_RST = 8'h00;
  // mask of bits that may feed the master summary
  localparam logic [7:0] MSUM_SRC_MASK = 8'hbc;
  // read port select codes
  typedef enum logic [1:0] {
    RD_POLL = 2'h0,
    RD_QUERY = 2'h1,
    RD_SRE = 2'h2,
    RD_STDEN = 2'h3
  } rd_sel_type;
endpackage

/* File: rtl/mask_reg.sv */
// Purpose: loadable enable mask register with reset value
// Assumes: same clock as its writer
// Notes: used for every enable mask of the block
`timescale 1ns/100ps
module mask_reg #(
  parameter int unsigned W = 8,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic wr_i,
  input wire logic [W-1:0] wdata_i,
  output logic [W-1:0] q_o
);
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      q_o <= RST;
    end else if (wr_i) begin
      q_o <= wdata_i;
    end
  end
endmodule // mask_reg

/* File: rtl/status_byte_service_request.sv */
// Purpose: summary status byte, master summary and service request flag
// Assumes: event registers, queues and command parser live outside
// Notes: read data and flags are registered; reads have no side effect
`timescale 1ns/100ps

module status_byte_service_request #(
  parameter int unsigned QW = status_byte_pkg::QUES_W,
  parameter int unsigned OW = status_byte_pkg::OPER_W
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic err_queue_empty_i,
  input wire logic out_queue_empty_i,
  input wire logic [QW-1:0] ques_event_i,
  input wire logic [OW-1:0] oper_event_i,
  input wire logic [status_byte_pkg::STD_W-1:0] std_event_i,
  input wire logic sre_wr_i,
  input wire logic std_en_wr_i,
  input wire logic ques_en_wr_i,
  input wire logic oper_en_wr_i,
  input wire logic [15:0] wdata_i,
  input wire logic rd_i,
  input wire logic [1:0] rd_sel_i,
  output logic [7:0] rdata_o,
  output logic rvalid_o,
  output logic [7:0] summary_status_byte_o,
  output logic master_summary_o,
  output logic service_request_flag_o
);
  import status_byte_pkg::*;

  // ****************************************************************
  // enable masks
  // ****************************************************************
  logic [7:0] sre_q;
  logic [7:0] std_en_q;
  logic [QW-1:0] ques_en_q;
  logic [OW-1:0] oper_en_q;

  mask_reg #(.W(8), .RST(SRE_RST)) u_sre (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .wr_i(sre_wr_i),
    .wdata_i(wdata_i[7:0]),
    .q_o(sre_q)
  );

  mask_reg #(.W(8), .RST(STD_EN_RST)) u_std_en (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .wr_i(std_en_wr_i),
    .wdata_i(wdata_i[7:0]),
    .q_o(std_en_q)
  );

  mask_reg #(.W(QW), .RST(QW'(QUES_EN_RST))) u_ques_en (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .wr_i(ques_en_wr_i),
    .wdata_i(wdata_i[QW-1:0]),
    .q_o(ques_en_q)
  );

  mask_reg #(.W(OW), .RST(OW'(OPER_EN_RST))) u_oper_en (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .wr_i(oper_en_wr_i),
    .wdata_i(wdata_i[OW-1:0]),
    .q_o(oper_en_q)
  );

  // ****************************************************************
  // summary bits
  // ****************************************************************
  function automatic logic any_enabled(input logic [15:0] ev,
                                       input logic [15:0] en);
    any_enabled = |(ev & en);
  endfunction

  // byte as the controller reads it, master summary in bit 6
  function automatic logic [7:0] poll_byte(input logic [7:0] stb,
                                           input logic msum);
    poll_byte = stb;
    poll_byte[BIT_MSUM] = msum;
  endfunction

  // ****************************************************************
  // event summaries
  // ****************************************************************
  // levels, not edges: a cleared source drops its bit
  logic err_pending;
  logic ques_pending;
  logic msg_pending;
  logic std_pending;
  logic oper_pending;

  assign err_pending = ~err_queue_empty_i;
  assign ques_pending = any_enabled(16'(ques_event_i), 16'(ques_en_q));
  assign msg_pending = ~out_queue_empty_i;
  assign std_pending = any_enabled(16'(std_event_i),
                                   16'(std_en_q));
  assign oper_pending = any_enabled(16'(oper_event_i),
                                    16'(oper_en_q));

  // ****************************************************************
  // status byte next value
  // ****************************************************************
  logic [7:0] stb_d;

  // reserved bits and bit 6 keep their reset value
  always_comb begin
    stb_d = STB_RST;
    stb_d[BIT_ERRQ] = err_pending;
    stb_d[BIT_QUES] = ques_pending;
    stb_d[BIT_MSGW] = msg_pending;
    stb_d[BIT_STDE] = std_pending;
    stb_d[BIT_OPER] = oper_pending;
  end

  // ****************************************************************
  // master summary
  // ****************************************************************
  logic [7:0] req_term;
  logic msum_d;

  // bit 6 and the reserved bits never raise a request
  for (genvar g = 0; g < 8; g++) begin : g_req_term
    assign req_term[g] = stb_d[g] & sre_q[g] & MSUM_SRC_MASK[g];
  end

  assign msum_d = |req_term;

  // ****************************************************************
  // status byte and request flag
  // ****************************************************************
  logic [7:0] stb_q;
  logic msum_q;
  logic srq_q;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      stb_q <= STB_RST;
    end else begin
      stb_q <= stb_d;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      msum_q <= STB_RST[BIT_MSUM];
    end else begin
      msum_q <= msum_d;
    end
  end

  // request flag follows master summary; reads never touch it
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      srq_q <= STB_RST[BIT_MSUM];
    end else begin
      srq_q <= msum_d;
    end
  end

  // ****************************************************************
  // read port
  // ****************************************************************
  logic [7:0] rdata_d;
  logic [7:0] rdata_q;
  logic rvalid_q;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= rd_i;
    end
  end

  // poll and query answer alike; data holds until the next read
  always_comb begin
    rdata_d = rdata_q;
    if (rd_i) begin
      unique case (rd_sel_type'(rd_sel_i))
        RD_POLL: rdata_d = poll_byte(stb_q, msum_q);
        RD_QUERY: rdata_d = poll_byte(stb_q, msum_q);
        RD_SRE: rdata_d = sre_q;
        RD_STDEN: rdata_d = std_en_q;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rdata_q <= STB_RST;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign summary_status_byte_o = stb_q;
  assign master_summary_o = msum_q;
  assign service_request_flag_o = srq_q;
  assign rdata_o = rdata_q;
  assign rvalid_o = rvalid_q;
endmodule // status_byte_service_request
